// ### parallel_port_control_word_programming_tb_top.sv
// self-checking bench for the parallel port decoder and its controller
`timescale 1ns/1ps
module parallel_port_control_word_programming_tb_top;
  import pio_pkg::*;
  logic                   clk;
  logic                   resetn;
  logic [ADDR_W-1:0]      sw_addr;
  logic [SW_W-1:0]        sw_wdata;
  logic                   sw_wr;
  logic                   sw_rd;
  logic [SW_W-1:0]        sw_rdata;
  logic                   irq;
  logic [1:0][BYTE_W-1:0] port_in;
  logic [1:0][BYTE_W-1:0] port_out;
  logic [1:0][BYTE_W-1:0] port_oe;
  logic [1:0]             port_rdy;
  int                     bad_count;
  int                     check_count;
  int                     m;
  pio_link_if pio_link_if_inst ();
  pio_host pio_host_inst (.clk(clk), .resetn(resetn), .link(pio_link_if_inst),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .irq(irq));
  pio_device pio_device_inst (.clk(clk), .resetn(resetn), .link(pio_link_if_inst),
    .port_in(port_in), .port_out(port_out), .port_oe(port_oe), .port_rdy(port_rdy));
  pio_link_assertions pio_link_assertions_inst (.clk(clk), .resetn(resetn),
    .wr(pio_link_if_inst.wr), .rd(pio_link_if_inst.rd),
    .port_b_sel(pio_link_if_inst.port_b_sel), .ctrl_sel(pio_link_if_inst.ctrl_sel),
    .wdata(pio_link_if_inst.wdata),
    .opcode_fetch_strobe_n(pio_link_if_inst.opcode_fetch_strobe_n),
    .rdata(pio_link_if_inst.rdata), .int_req(pio_link_if_inst.int_req));
  // ---------------------------------------------------------------
  // clock and access tasks
  // ---------------------------------------------------------------
  initial clk = 1'b0;
  always #50 clk = ~clk;
  // shared compare so every check is counted the same way
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic sw_read(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    check(sw_rdata, exp);
  endtask
  task automatic link(input logic b, input logic c, input logic [7:0] d);
    sw_write(REG_CMD, {4'h0, 1'b0, 1'b0, b, c, d});
    repeat (3) @(posedge clk);
  endtask
  task automatic link_read(input logic b, input logic c, input logic [7:0] exp);
    sw_write(REG_CMD, {4'h0, 1'b0, 1'b1, b, c, 8'h00});
    repeat (3) @(posedge clk);
    sw_read(REG_RDATA, {8'h00, exp});
  endtask
  task automatic fetch;
    sw_write(REG_CMD, 16'h0800);
    repeat (3) @(posedge clk);
  endtask
  // pins pass two sync stages, so settle generously
  task automatic pins(input logic [7:0] v);
    @(posedge clk);
    port_in[0] <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    resetn = 1'b0;
    sw_addr = '0;
    sw_wdata = '0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    port_in = '0;
    bad_count = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    sw_read(REG_STATUS, SW_ZERO);
    sw_read(4'h2, SW_ZERO);
    // port b select reaches only port b
    link(1'b1, 1'b1, 8'h0F);
    link(1'b1, 1'b0, 8'h3C);
    check({port_out[1], port_out[0]}, 16'h3C00);
    check({7'h00, port_rdy[1], port_oe[1]}, 16'h01FF);
    // each plain mode sets drivers and leaves ready high
    for (m = 0; m < 3; m++) begin
      link(1'b0, 1'b1, {m[1:0], 6'h0F});
      check({7'h00, port_rdy[0], port_oe[0]}, {7'h00, 1'b1, (m == 0) ? 8'hFF : 8'h00});
    end
    link(1'b0, 1'b1, 8'hCF);
    link(1'b0, 1'b1, 8'h29);
    check({7'h00, port_rdy[0], port_oe[0]}, 16'h00D6);
    link(1'b0, 1'b1, 8'hA4);
    link(1'b0, 1'b0, 8'h80);
    link_read(1'b0, 1'b1, 8'hA4);
    // or, high, mask follows; a7 output excluded
    link(1'b0, 1'b1, 8'hB7);
    link(1'b0, 1'b1, 8'hD6);
    fetch();
    sw_write(REG_STATUS, 16'h0003);
    sw_write(REG_MASK, 16'h0002);
    sw_read(REG_MASK, 16'h0002);
    pins(8'h20);
    sw_read(REG_STATUS, 16'h0002);
    check({15'h0000, irq}, 16'h0001);
    // a second line going active raises nothing new
    sw_write(REG_STATUS, 16'h0003);
    pins(8'h28);
    sw_read(REG_STATUS, SW_ZERO);
    link_read(1'b0, 1'b0, 8'hA8);
    // monitor a7, a5, a3 and a0; only the a7 output goes high
    pins(8'h00);
    link(1'b0, 1'b0, 8'h00);
    link(1'b0, 1'b1, 8'hB7);
    link(1'b0, 1'b1, 8'h56);
    fetch();
    sw_write(REG_STATUS, 16'h0003);
    link(1'b0, 1'b0, 8'h80);
    repeat (4) @(posedge clk);
    sw_read(REG_STATUS, 16'h0003);
    // enable off and on again keeps or, level and mask
    link(1'b0, 1'b1, 8'h03);
    link(1'b0, 1'b0, 8'h00);
    link(1'b0, 1'b1, 8'h83);
    sw_write(REG_STATUS, 16'h0003);
    link(1'b0, 1'b0, 8'h80);
    repeat (4) @(posedge clk);
    sw_read(REG_STATUS, 16'h0003);
    // and with active low over a5 and a0
    pins(8'h01);
    link(1'b0, 1'b1, 8'hD7);
    link(1'b0, 1'b1, 8'hDE);
    // condition comes true before the fetch edge: enable not yet applied
    sw_write(REG_STATUS, 16'h0003);
    pins(8'h00);
    sw_read(REG_STATUS, SW_ZERO);
    fetch();
    sw_write(REG_STATUS, 16'h0003);
    pins(8'h20);
    sw_read(REG_STATUS, SW_ZERO);
    pins(8'h00);
    sw_read(REG_STATUS, 16'h0002);
    check({15'h0000, irq}, 16'h0001);
    sw_write(REG_MASK, SW_ZERO);
    repeat (3) @(posedge clk);
    check({15'h0000, irq}, SW_ZERO);
    summarize();
  end
endmodule

// ### pio_device.sv
// dual parallel port device: control byte decoder and bit-control interrupt logic
// Contract
// - low nibble all ones selects port mode
// - after bit mode, next byte sets directions
// - even byte loads vector, bit zero zero
// - nibble 0111 sets enable, and/or, level, mask-follows
// - mask-follows makes next byte the mask
// - mask zero monitors line, one excludes it
// - nibble 0011 changes only interrupt enable
// - or plus high: any monitored line high
// - output lines judged from output register
// - selects pick port and control or data
// - interrupt only on false-to-true change
// - ready held low in bit mode
// - bit mode read mixes outputs and inputs
// - enable applies at opcode fetch rising edge
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module pio_device (
  input  wire logic                                  clk,
  input  wire logic                                  resetn,
  pio_link_if.dev_end                                link,
  input  wire logic [1:0][pio_pkg::BYTE_W-1:0]       port_in,
  output logic      [1:0][pio_pkg::BYTE_W-1:0]       port_out,
  output logic      [1:0][pio_pkg::BYTE_W-1:0]       port_oe,
  output logic      [1:0]                            port_rdy
);
  import pio_pkg::*;

  // ---------------------------------------------------------------
  // combining of monitored lines
  // ---------------------------------------------------------------
  // an all-masked port never fires, whatever the combining
  function automatic logic cond_f(input logic [7:0] lines, input logic [7:0] mask,
                                  input logic use_and, input logic high);
    logic [7:0] act;
    act = high ? lines : ~lines;
    if (use_and) begin
      cond_f = (&(act | mask)) && (mask != BYTE_ONES);
    end else begin
      cond_f = |(act & ~mask);
    end
  endfunction

  logic [1:0][7:0] rd_val_w;
  logic [1:0]      pend_w;
  logic [7:0]      rdata_q;
  logic            int_req_q;
  logic            fetch_prev_q;

  wire fetch_low  = ~link.opcode_fetch_strobe_n;
  wire fetch_rise = link.opcode_fetch_strobe_n & ~fetch_prev_q;

  // ---------------------------------------------------------------
  // per-port logic
  // ---------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [7:0] in_meta_q;
    logic [7:0] in_sync_q;
    logic [7:0] out_q;
    logic [7:0] dir_q;
    logic [7:0] mask_q;
    logic [7:0] oe_q;
    logic [6:0] vec_q;
    logic [1:0] mode_q;
    logic       ie_q;
    logic       and_q;
    logic       high_q;
    logic       arm_q;
    logic       arm_val_q;
    logic       cond_q;
    logic       pend_q;
    logic       rdy_q;
    phase_type  ph_q;

    // port and register selection
    wire sel    = (p == 1) ? link.port_b_sel : ~link.port_b_sel;
    wire wr_ctl = link.wr & link.ctrl_sel & sel;
    wire wr_dat = link.wr & ~link.ctrl_sel & sel;
    wire rd_dat = link.rd & ~link.ctrl_sel & sel;
    wire [3:0] nib   = link.wdata[3:0];
    wire is_cmd      = wr_ctl && (ph_q == PH_CMD);
    wire is_mode     = is_cmd && (nib == MODE_NIB);
    wire is_vec      = is_cmd && !link.wdata[VEC_FLAG];
    wire is_ictl     = is_cmd && (nib == ICTL_NIB);
    wire is_ien      = is_cmd && (nib == IEN_NIB);
    wire [1:0] new_mode = link.wdata[MODE_HI:MODE_LO];
    // output lines are judged from what the port drives, not from the pins
    wire [7:0] lines = (dir_q & in_sync_q) | (~dir_q & out_q);
    wire cond        = cond_f(lines, mask_q, and_q, high_q);

    assign rd_val_w[p] = (mode_q == MODE_BIT) ? lines :
                                     (mode_q == MODE_OUT) ? out_q : in_sync_q;
    assign pend_w[p]   = pend_q;
    assign port_out[p] = out_q;
    assign port_oe[p]  = oe_q;
    assign port_rdy[p] = rdy_q;

    // pins come from outside: two flops before anything reads them
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        in_meta_q <= BYTE_ZERO;
        in_sync_q <= BYTE_ZERO;
      end else begin
        in_meta_q <= port_in[p];
        in_sync_q <= in_meta_q;
      end
    end

    // control byte sequencing; a byte expected as direction or mask is never decoded
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        ph_q   <= PH_CMD;
        mode_q <= MODE_RESET;
        dir_q  <= DIR_RESET;
        mask_q <= MASK_RESET;
        vec_q  <= 7'h00;
        and_q  <= 1'b0;
        high_q <= 1'b0;
      end else if (wr_ctl) begin
        if (ph_q == PH_DIR) begin
          dir_q <= link.wdata;
          ph_q  <= PH_CMD;
        end else if (ph_q == PH_MASK) begin
          mask_q <= link.wdata;
          ph_q   <= PH_CMD;
        end else if (is_mode) begin
          mode_q <= new_mode;
          if (new_mode == MODE_BIT) begin
            ph_q <= PH_DIR;
          end
        end else if (is_vec) begin
          vec_q <= link.wdata[7:1];
        end else if (is_ictl) begin
          and_q  <= link.wdata[ICTL_AND];
          high_q <= link.wdata[ICTL_HIGH];
          if (link.wdata[ICTL_MASKF]) begin
            ph_q <= PH_MASK;
          end
        end
      end
    end

    // enable: the control word arms it, the next fetch rising edge with no mask byte awaited applies it
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        ie_q      <= 1'b0;
        arm_q     <= 1'b0;
        arm_val_q <= 1'b0;
      end else if (is_ictl) begin
        ie_q      <= 1'b0;
        arm_q     <= 1'b1;
        arm_val_q <= link.wdata[ICTL_EN];
      end else if (is_ien) begin
        ie_q  <= link.wdata[ICTL_EN];
        arm_q <= 1'b0;
      end else if (arm_q && fetch_rise && ph_q != PH_MASK) begin
        ie_q  <= arm_val_q;
        arm_q <= 1'b0;
      end
    end

    // edge-detected request; frozen while the fetch strobe is low so the chain settles
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        cond_q <= 1'b0;
        pend_q <= 1'b0;
      end else if (!fetch_low) begin
        cond_q <= cond;
        if (mode_q == MODE_BIT && ie_q && cond && !cond_q) begin
          pend_q <= 1'b1;
        end else if (rd_dat || wr_dat || !ie_q) begin
          pend_q <= 1'b0;
        end
      end
    end

    // output register, drivers and ready
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        out_q <= BYTE_ZERO;
        oe_q  <= BYTE_ZERO;
        rdy_q <= 1'b0;
      end else begin
        if (wr_dat) begin
          out_q <= link.wdata;
        end
        oe_q  <= (mode_q == MODE_BIT) ? ~dir_q : (mode_q == MODE_OUT) ? BYTE_ONES : BYTE_ZERO;
        rdy_q <= (mode_q != MODE_BIT);
      end
    end
  end

  // ---------------------------------------------------------------
  // read data and interrupt request
  // ---------------------------------------------------------------
  wire [7:0] vec_rd = link.port_b_sel ? {g_port[1].vec_q, 1'b0} : {g_port[0].vec_q, 1'b0};
  wire [7:0] rd_mux = link.ctrl_sel ? vec_rd : rd_val_w[link.port_b_sel];

  // read data stand for exactly the cycle after the read strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q      <= BYTE_ZERO;
      int_req_q    <= 1'b0;
      fetch_prev_q <= 1'b1;
    end else begin
      rdata_q      <= link.rd ? rd_mux : BYTE_ZERO;
      int_req_q    <= |pend_w;
      fetch_prev_q <= link.opcode_fetch_strobe_n;
    end
  end

  assign link.rdata   = rdata_q;
  assign link.int_req = int_req_q;
endmodule

// ### pio_host.sv
// processor-side controller: turns software commands into port accesses
`timescale 1ns/1ps
module pio_host (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  pio_link_if.host_end                       link,
  input  wire logic [pio_pkg::ADDR_W-1:0]    sw_addr,
  input  wire logic [pio_pkg::SW_W-1:0]      sw_wdata,
  input  wire logic                          sw_wr,
  input  wire logic                          sw_rd,
  output logic      [pio_pkg::SW_W-1:0]      sw_rdata,
  output logic                               irq
);
  import pio_pkg::*;

  logic       wr_q;
  logic       rd_q;
  logic       fetch_n_q;
  logic       port_b_q;
  logic       ctl_q;
  logic [7:0] wdata_q;
  logic       rd_pend_q;
  logic [7:0] cap_q;
  logic       int_prev_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic       irq_q;
  logic [15:0] sw_rdata_q;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire cmd_wr    = sw_wr && (sw_addr == REG_CMD);
  wire is_fetch  = sw_wdata[CMD_FETCH];
  wire is_read   = sw_wdata[CMD_READ] && !is_fetch;
  wire done_ev   = wr_q | rd_pend_q | ~fetch_n_q;
  wire int_ev    = link.int_req & ~int_prev_q;
  wire [1:0] ev  = {int_ev, done_ev};
  wire [1:0] w1c = (sw_wr && sw_addr == REG_STATUS) ? sw_wdata[1:0] : STAT_ZERO;
  wire [1:0] status_d = ev | (status_q & ~w1c);
  wire [15:0] rd_mux = (sw_addr == REG_RDATA)  ? {8'h00, cap_q} :
                       (sw_addr == REG_STATUS) ? {14'h0000, status_q} :
                       (sw_addr == REG_MASK)   ? {14'h0000, mask_q} : SW_ZERO;

  // control bytes go out unchanged and in order; software owns the sequence
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      fetch_n_q <= 1'b1;
      port_b_q  <= 1'b0;
      ctl_q     <= 1'b0;
      wdata_q   <= BYTE_ZERO;
    end else begin
      wr_q      <= cmd_wr && !is_read && !is_fetch;
      rd_q      <= cmd_wr && is_read;
      fetch_n_q <= !(cmd_wr && is_fetch);
      if (cmd_wr) begin
        port_b_q <= sw_wdata[CMD_PORTB];
        ctl_q    <= sw_wdata[CMD_CTL];
        wdata_q  <= sw_wdata[7:0];
      end
    end
  end

  // capture device read data in the cycle it stands
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_pend_q  <= 1'b0;
      cap_q      <= BYTE_ZERO;
      int_prev_q <= 1'b0;
    end else begin
      rd_pend_q  <= rd_q;
      int_prev_q <= link.int_req;
      if (rd_pend_q) begin
        cap_q <= link.rdata;
      end
    end
  end

  // sticky status: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_q   <= STAT_ZERO;
      mask_q     <= STAT_ZERO;
      irq_q      <= 1'b0;
      sw_rdata_q <= SW_ZERO;
    end else begin
      status_q <= status_d;
      if (sw_wr && sw_addr == REG_MASK) begin
        mask_q <= sw_wdata[1:0];
      end
      irq_q      <= |(status_q & mask_q);
      sw_rdata_q <= sw_rd ? rd_mux : SW_ZERO;
    end
  end

  assign link.wr                    = wr_q;
  assign link.rd                    = rd_q;
  assign link.opcode_fetch_strobe_n = fetch_n_q;
  assign link.port_b_sel            = port_b_q;
  assign link.ctrl_sel              = ctl_q;
  assign link.wdata                 = wdata_q;
  assign sw_rdata                   = sw_rdata_q;
  assign irq                        = irq_q;
endmodule

// ### pio_link_assertions.sv
// link protocol checker watching both ends of the parallel port link
`timescale 1ns/1ps
module pio_link_assertions (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic       port_b_sel,
  input wire logic       ctrl_sel,
  input wire logic [7:0] wdata,
  input wire logic       opcode_fetch_strobe_n,
  input wire logic [7:0] rdata,
  input wire logic       int_req
);
  import pio_pkg::*;
  // ---------------------------------------------------------------
  // clocking and steps
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // port a enable-off command; port b never holds a request in use here
  sequence ien_off;
    wr && ctrl_sel && !port_b_sel && wdata[3:0] == IEN_NIB && !wdata[ICTL_EN];
  endsequence
  // three idle cycles cover the slowest clearing path
  sequence quiet_then_req;
    (!wr && !rd) [*3] ##0 int_req;
  endsequence
  sequence data_read_a;
    rd && !ctrl_sel && !port_b_sel;
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_ien_clear_drop: assert property (ien_off |-> ##3 !int_req)
    else $error("request stayed after enable was cleared");
  a_req_holds: assert property (quiet_then_req |=> int_req)
    else $error("request dropped without a port access");
  a_read_clears: assert property (data_read_a |-> ##2 !int_req)
    else $error("request stayed after data read");
  a_rdata_idle_zero: assert property (!rd |=> rdata == BYTE_ZERO)
    else $error("read data outside the answer cycle");
  a_strobe_excl: assert property (!(wr && rd))
    else $error("write and read strobes together");
  a_fetch_pulse_short: assert property ($fell(opcode_fetch_strobe_n) |=> opcode_fetch_strobe_n)
    else $error("fetch strobe low longer than one cycle");
  // the request flop lags the pending flag by one cycle, so look two cycles back
  a_req_after_fetch: assert property ($rose(int_req) |-> $past(opcode_fetch_strobe_n, 2))
    else $error("request rose while fetch strobe was low");
  a_vector_bit_zero: assert property (rd && ctrl_sel |=> !rdata[VEC_FLAG])
    else $error("control read bit zero set");
endmodule

// ### pio_link_if.sv
// link between the processor-side controller and the parallel port device
`timescale 1ns/1ps
interface pio_link_if;
  logic       wr;
  logic       rd;
  logic       port_b_sel;
  logic       ctrl_sel;
  logic [7:0] wdata;
  logic       opcode_fetch_strobe_n;
  logic [7:0] rdata;
  logic       int_req;
  modport host_end (
    output wr,
    output rd,
    output port_b_sel,
    output ctrl_sel,
    output wdata,
    output opcode_fetch_strobe_n,
    input  rdata,
    input  int_req
  );
  modport dev_end (
    input  wr,
    input  rd,
    input  port_b_sel,
    input  ctrl_sel,
    input  wdata,
    input  opcode_fetch_strobe_n,
    output rdata,
    output int_req
  );
endinterface

// ### pio_pkg.sv
// shared constants for the parallel port command decoder and its controller
package pio_pkg;
  localparam int BYTE_W = 8;
  localparam int SW_W   = 16;
  localparam int ADDR_W = 4;
  // ---------------------------------------------------------------
  // control byte decoding
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_NIB = 4'hF;
  localparam logic [3:0] ICTL_NIB = 4'h7;
  localparam logic [3:0] IEN_NIB  = 4'h3;
  localparam int MODE_HI    = 7;
  localparam int MODE_LO    = 6;
  localparam int ICTL_EN    = 7;
  localparam int ICTL_AND   = 6;
  localparam int ICTL_HIGH  = 5;
  localparam int ICTL_MASKF = 4;
  localparam int VEC_FLAG   = 0;
  localparam logic [1:0] MODE_OUT   = 2'h0;
  localparam logic [1:0] MODE_IN    = 2'h1;
  localparam logic [1:0] MODE_BIDIR = 2'h2;
  localparam logic [1:0] MODE_BIT   = 2'h3;
  localparam logic [1:0] MODE_RESET = MODE_IN;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [7:0] BYTE_ONES  = 8'hFF;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] DIR_RESET  = 8'hFF;
  typedef enum logic [1:0] {PH_CMD, PH_DIR, PH_MASK} phase_type;
  // ---------------------------------------------------------------
  // controller register map and fields
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_RDATA  = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_MASK   = 4'hC;
  localparam int CMD_CTL   = 8;
  localparam int CMD_PORTB = 9;
  localparam int CMD_READ  = 10;
  localparam int CMD_FETCH = 11;
  localparam int STAT_DONE = 0;
  localparam int STAT_INT  = 1;
  localparam logic [1:0] STAT_ZERO = 2'h0;
  localparam logic [15:0] SW_ZERO  = 16'h0000;
endpackage
